// File: logic/rth_host_regs.v
`include "rth_regs_map.vh"
module rth_host_regs
(
  // Clock and reset
  input wire SYS_CLK_I,
  input wire RESET_N_I,
  // Host register port
  input wire CHIP_SEL_N_I,
  input wire REG_SEL_N_I,
  input wire RD_WR_I,
  input wire ADDR0_I,
  input wire [15:0] DATA_I,
  output reg [15:0] DATA_O,
  output wire DATA_OE_O,
  // Core status inputs
  input wire CMD_VALID_I,
  input wire [15:0] CMD_WORD_I,
  input wire CMD_ON_A_I,
  input wire MODE_INHIBIT_FLAG_I,
  input wire MODE_OVERRIDE_FLAG_I,
  input wire MODE_LAST_CMD_I,
  input wire ILLEGAL_CMD_I,
  input wire ADDR_LATCH_LOAD_I,
  input wire ADDR_PARITY_OK_I,
  input wire MSG_ERROR_I,
  input wire VALID_MSG_I,
  input wire TRANSMIT_ACTIVE_N_I,
  input wire RECEIVE_ACTIVE_N_I,
  input wire SELFTEST_DONE_I,
  // Core control outputs
  output wire MASTER_RESET_O,
  output wire CHANNEL_A_ENABLE_O,
  output wire CHANNEL_B_ENABLE_O,
  output wire TERMINAL_FLAG_CTL_O,
  output wire SUBSYSTEM_BUSY_CTL_O,
  output wire SERVICE_REQUEST_CTL_O,
  output wire DATA_MEM_INHIBIT_O,
  output wire SELFTEST_ACTIVE_O,
  output wire SELFTEST_CHANNEL_CTL_O,
  output wire BIPHASE_OUT_ENABLE_O,
  output wire MSG_ERROR_FLAG_O,
  output reg [15:0] LAST_CMD_O
);
  reg [7:0] ctl_q;
  reg [4:0] code_or_subaddress_field_q;
  reg mode_code_not_subaddress_q;
  reg chan_a_q;
  reg flag_enable_status_q;
  reg address_parity_error_q;
  reg selftest_q;
  reg wr_q;
  reg rd_q;
  wire access;
  wire wr_now;
  wire ctl_write;
  wire status_read;
  wire message_error_flag;
  wire valid_message_flag;
  wire terminal_active_flag;
  wire [15:0] status;

  // Subaddress 0 and 31 mark a mode code.
  function is_mode_code;
    input [4:0] sub;
    begin
      is_mode_code = (sub == 5'h00) || (sub == 5'h1F);
    end
  endfunction

  // ----------------------------------------
  // Host access decode
  // ----------------------------------------
  assign access = !CHIP_SEL_N_I && !REG_SEL_N_I;
  assign wr_now = access && !RD_WR_I;
  // Acting once per strobe keeps a long host cycle from repeating the effect.
  assign ctl_write = wr_now && !ADDR0_I && !wr_q; // [R1]
  assign MASTER_RESET_O = wr_now && ADDR0_I && !wr_q; // [R2]
  assign status_read = access && RD_WR_I && !ADDR0_I; // [R11]
  assign DATA_OE_O = status_read; // [R11]

  always @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_now;
      rd_q <= status_read;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Master reset returns every control bit to zero.
  always @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      ctl_q <= `RTH_CTL_RESET;
    else if (MASTER_RESET_O)
      ctl_q <= `RTH_CTL_RESET; // [R2]
    else if (ctl_write)
      ctl_q <= DATA_I[7:0]; // [R1] [R10]
  end

  assign CHANNEL_A_ENABLE_O = ctl_q[`RTH_CTL_CHA_BIT] && !address_parity_error_q; // [R4] [R18]
  assign CHANNEL_B_ENABLE_O = ctl_q[`RTH_CTL_CHB_BIT] && !address_parity_error_q; // [R4] [R18]
  assign TERMINAL_FLAG_CTL_O = ctl_q[`RTH_CTL_TF_BIT] && flag_enable_status_q; // [R5] [R15]
  assign DATA_MEM_INHIBIT_O = ctl_q[`RTH_CTL_BUSY_BIT]; // [R6]
  assign SUBSYSTEM_BUSY_CTL_O = ctl_q[`RTH_CTL_SUBSYSTEM_BUSY_CTL_BIT]; // [R7]
  assign SELFTEST_CHANNEL_CTL_O = ctl_q[`RTH_CTL_STCH_BIT]; // [R8]
  assign SELFTEST_ACTIVE_O = selftest_q; // [R9]
  assign BIPHASE_OUT_ENABLE_O = !selftest_q; // [R9]
  assign SERVICE_REQUEST_CTL_O = ctl_q[`RTH_CTL_SRQ_BIT]; // [R10]

  // ----------------------------------------
  // Status state
  // ----------------------------------------
  always @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      code_or_subaddress_field_q <= 5'h00;
      mode_code_not_subaddress_q <= 1'b0;
      chan_a_q <= 1'b1;
      flag_enable_status_q <= 1'b1;
      address_parity_error_q <= 1'b0;
      selftest_q <= 1'b0;
      LAST_CMD_O <= `RTH_LAST_CMD_RESET;
    end
    else
    begin
      if (CMD_VALID_I)
      begin
        // A mode code sits in the low five bits, so showing the subaddress field would hide it.
        code_or_subaddress_field_q <= is_mode_code(CMD_WORD_I[9:5]) ? CMD_WORD_I[4:0] : CMD_WORD_I[9:5]; // [R12]
        mode_code_not_subaddress_q <= !is_mode_code(CMD_WORD_I[9:5]); // [R12]
        chan_a_q <= CMD_ON_A_I; // [R13]
      end
      if (MODE_INHIBIT_FLAG_I)
        flag_enable_status_q <= 1'b0; // [R15]
      else if (MODE_OVERRIDE_FLAG_I)
        flag_enable_status_q <= 1'b1;
      if (ADDR_LATCH_LOAD_I)
        address_parity_error_q <= !ADDR_PARITY_OK_I; // [R18]
      if (ctl_write && DATA_I[`RTH_CTL_ST_BIT])
        selftest_q <= 1'b1; // [R9]
      else if (SELFTEST_DONE_I || !ctl_q[`RTH_CTL_ST_BIT] || MASTER_RESET_O)
        selftest_q <= 1'b0; // [R17]
      // Transmit-last-command replays the previous word, so it is not stored.
      if (CMD_VALID_I && !MODE_LAST_CMD_I)
        LAST_CMD_O <= {ILLEGAL_CMD_I, CMD_ON_A_I, flag_enable_status_q, selftest_q,
                       ctl_q[`RTH_CTL_BUSY_BIT], CMD_WORD_I[10:0]}; // [R22]
    end
  end

  rth_flag_latch u_msg_err
  (
    .clk_i(SYS_CLK_I),
    .reset_n_i(RESET_N_I),
    .set_i(MSG_ERROR_I || address_parity_error_q),
    .hold_i(MSG_ERROR_I || address_parity_error_q),
    .read_i(rd_q && !status_read),
    .flag_o(message_error_flag)
  ); // [R19]

  rth_flag_latch u_val_msg
  (
    .clk_i(SYS_CLK_I),
    .reset_n_i(RESET_N_I),
    .set_i(VALID_MSG_I),
    .hold_i(1'b0),
    .read_i(rd_q && !status_read),
    .flag_o(valid_message_flag)
  ); // [R20]

  assign MSG_ERROR_FLAG_O = message_error_flag;
  assign terminal_active_flag = !(TRANSMIT_ACTIVE_N_I && RECEIVE_ACTIVE_N_I); // [R21]

  // ----------------------------------------
  // Status word and read data
  // ----------------------------------------
  assign status = {terminal_active_flag, valid_message_flag, message_error_flag, address_parity_error_q,
                   selftest_q, ctl_q[`RTH_CTL_BUSY_BIT], flag_enable_status_q, CHANNEL_A_ENABLE_O,
                   CHANNEL_B_ENABLE_O, chan_a_q, mode_code_not_subaddress_q,
                   code_or_subaddress_field_q}; // [R12] [R13] [R14] [R16]

  always @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      DATA_O <= 16'h0000;
    else if (status_read)
      DATA_O <= status; // [R11]
    else
      DATA_O <= 16'h0000;
  end
endmodule // rth_host_regs

// File: logic/rth_regs_map.vh
`ifndef RTH_REGS_MAP_VH
`define RTH_REGS_MAP_VH
// What this block does and what it expects of the host
// [R1] Control write when chip select, register select, strobe and address 0 all low.
// [R2] A register write with address bit 0 high issues a master reset.
// [R3] Host finishes control writes 50 ns before command strobe rises.
// [R4] Control bits 0 and 1 enable channel A and channel B receiver inputs.
// [R5] Control bit 2 sets the terminal flag of the status word.
// [R6] Control bit 3 sets busy, stops data word memory access, commands still stored.
// [R7] Control bit 4 sets the subsystem flag of the status word.
// [R8] Control bit 5 picks the self-test channel: one is A, zero is B.
// [R9] Control bit 6 enters self-test, inhibits normal work, hides it from outputs.
// [R10] Control bit 7 sets service request; data bits above 7 are ignored.
// [R11] Status read when selects and address 0 low, strobe high; all 16 bits driven.
// [R12] Status bits 4..0 hold the last command field; bit 5 one means subaddress.
// [R13] Status bit 6 gives the channel of the last command; resets to one.
// [R14] Status bit 7 shows channel B available, bit 8 channel A available.
// [R15] Status bit 9 resets to one, cleared by inhibit flag code; gates terminal flag.
// [R16] Status bit 10 shows busy and clears only when the busy control bit clears.
// [R17] Status bit 11 is one during self-test and clears when it ends.
// [R18] Status bit 12 flags bad address parity; disables inputs, raises message error.
// [R19] Status bit 13 latches message errors until read and error gone.
// [R20] Status bit 14 latches valid messages until the status is read.
// [R21] Status bit 15 is the NAND of transmit and receive active pins.
// [R22] A last-command register captures the command word and status for replay.
// [R23] Host keeps register accesses few while a bus message is processed.
`define RTH_CTL_RESET 8'h00
`define RTH_CTL_CHA_BIT 0
`define RTH_CTL_CHB_BIT 1
`define RTH_CTL_TF_BIT 2
`define RTH_CTL_BUSY_BIT 3
`define RTH_CTL_SUBSYSTEM_BUSY_CTL_BIT 4
`define RTH_CTL_STCH_BIT 5
`define RTH_CTL_ST_BIT 6
`define RTH_CTL_SRQ_BIT 7
`define RTH_LAST_CMD_RESET 16'hFFFF
`define RTH_CMD_SETUP_NS 50
`define RTH_CLK_PERIOD_NS 25
`define RTH_CMD_SETUP_CYC ((`RTH_CMD_SETUP_NS + `RTH_CLK_PERIOD_NS - 1) / `RTH_CLK_PERIOD_NS)
`endif

// File: logic/rth_flag_latch.v
`include "rth_regs_map.vh"
module rth_flag_latch
(
  input wire clk_i,
  input wire reset_n_i,
  input wire set_i,
  input wire hold_i,
  input wire read_i,
  output reg flag_o
);
  reg read_seen_q;

  // ----------------------------------------
  // Sticky flag cleared after a read
  // ----------------------------------------
  // Setting wins over clearing, so an event in the read cycle is kept.
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      flag_o <= 1'b0;
      read_seen_q <= 1'b0;
    end
    else if (set_i)
    begin
      flag_o <= 1'b1;
      read_seen_q <= 1'b0;
    end
    else if (flag_o && (read_i || read_seen_q))
    begin
      if (!hold_i)
      begin
        flag_o <= 1'b0;
        read_seen_q <= 1'b0;
      end
      else
      begin
        read_seen_q <= 1'b1;
      end
    end
  end
endmodule // rth_flag_latch

// File: verification/rth_host_regs_props.sv
module rth_host_regs_props
(
  input wire SYS_CLK_I, RESET_N_I, CHIP_SEL_N_I, REG_SEL_N_I, RD_WR_I, ADDR0_I,
  input wire [15:0] DATA_I,
  input wire [15:0] DATA_O,
  input wire DATA_OE_O, TRANSMIT_ACTIVE_N_I, RECEIVE_ACTIVE_N_I, MSG_ERROR_I, MASTER_RESET_O,
  input wire DATA_MEM_INHIBIT_O, SERVICE_REQUEST_CTL_O, SELFTEST_ACTIVE_O, BIPHASE_OUT_ENABLE_O, MSG_ERROR_FLAG_O
);
  timeunit 1ns;
  timeprecision 1ps;
  wire sel = !CHIP_SEL_N_I && !REG_SEL_N_I;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  // ------
  // Checks
  // ------
  read_decode_a: assert property (DATA_OE_O == (sel && RD_WR_I && !ADDR0_I))
    else $error("read enable off decode");
  read_word_a: assert property ($past(DATA_OE_O) |->
    DATA_O[15] != ($past(TRANSMIT_ACTIVE_N_I) && $past(RECEIVE_ACTIVE_N_I))) else $error("active bit wrong");
  read_idle_a: assert property (!$past(DATA_OE_O) |-> DATA_O == 16'h0000)
    else $error("data driven outside read");
  master_reset_a: assert property (MASTER_RESET_O |-> sel && !RD_WR_I && ADDR0_I ##1 !MASTER_RESET_O)
    else $error("master reset pulse wrong");
  ctl_load_a: assert property (sel && !RD_WR_I && !ADDR0_I && $past(RD_WR_I) |=>
    SERVICE_REQUEST_CTL_O == $past(DATA_I[7]) && DATA_MEM_INHIBIT_O == $past(DATA_I[3])) else $error("ctl load");
  busy_hold_a: assert property (!(sel && !RD_WR_I) |=> $stable(DATA_MEM_INHIBIT_O))
    else $error("busy moved without write");
  selftest_out_a: assert property (BIPHASE_OUT_ENABLE_O != SELFTEST_ACTIVE_O)
    else $error("self-test visible on outputs");
  msg_latch_a: assert property (MSG_ERROR_I |=> MSG_ERROR_FLAG_O)
    else $error("message error not latched");
  cover property (sel && !RD_WR_I && !ADDR0_I);
  cover property (MASTER_RESET_O);
  cover property (DATA_OE_O ##1 DATA_O[14]);
endmodule // rth_host_regs_props
bind rth_host_regs rth_host_regs_props u_props (.*);

// File: verification/rth_host_model.sv
module rth_host_model
(
  input wire clk_i,
  input wire [15:0] data_i,
  output logic chip_sel_n_o,
  output logic reg_sel_n_o,
  output logic rd_wr_o,
  output logic addr0_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------
  // Host bus
  // ---------
  initial
  begin
    {chip_sel_n_o, reg_sel_n_o, rd_wr_o, addr0_o} = 4'hF;
    data_o = 16'h0000;
  end
  // Released data lines are inverted, so after a write they no longer hold the written word until a read's release inverts them back.
  task automatic release_bus();
    {chip_sel_n_o, reg_sel_n_o, rd_wr_o, addr0_o} = 4'hF;
    data_o = ~data_o;
  endtask
  task automatic wr(input logic a0, input logic [15:0] d);
    @(negedge clk_i);
    {chip_sel_n_o, reg_sel_n_o, rd_wr_o, addr0_o, data_o} = {3'h0, a0, d};
    @(negedge clk_i);
    release_bus();
    @(negedge clk_i);
  endtask
  task automatic rd(output logic [15:0] d);
    @(negedge clk_i);
    {chip_sel_n_o, reg_sel_n_o, rd_wr_o, addr0_o} = 4'h2;
    @(negedge clk_i);
    d = data_i;
    release_bus();
  endtask
endmodule // rth_host_model

// File: verification/test_rth_host_regs.sv
module test_rth_host_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK_I, RESET_N_I, CMD_VALID_I, CMD_ON_A_I, MODE_INHIBIT_FLAG_I, MODE_OVERRIDE_FLAG_I, MODE_LAST_CMD_I;
  logic ILLEGAL_CMD_I, ADDR_LATCH_LOAD_I, ADDR_PARITY_OK_I, MSG_ERROR_I, VALID_MSG_I, TRANSMIT_ACTIVE_N_I;
  logic RECEIVE_ACTIVE_N_I, SELFTEST_DONE_I;
  logic [15:0] CMD_WORD_I;
  wire CHIP_SEL_N_I, REG_SEL_N_I, RD_WR_I, ADDR0_I, DATA_OE_O, MASTER_RESET_O, CHANNEL_A_ENABLE_O;
  wire CHANNEL_B_ENABLE_O, TERMINAL_FLAG_CTL_O, SUBSYSTEM_BUSY_CTL_O, SERVICE_REQUEST_CTL_O, DATA_MEM_INHIBIT_O;
  wire SELFTEST_ACTIVE_O, SELFTEST_CHANNEL_CTL_O, BIPHASE_OUT_ENABLE_O, MSG_ERROR_FLAG_O;
  wire [15:0] DATA_I, DATA_O, LAST_CMD_O;
  wire [7:0] ctl = {SERVICE_REQUEST_CTL_O, SELFTEST_ACTIVE_O, SELFTEST_CHANNEL_CTL_O, SUBSYSTEM_BUSY_CTL_O,
    DATA_MEM_INHIBIT_O, TERMINAL_FLAG_CTL_O, CHANNEL_B_ENABLE_O, CHANNEL_A_ENABLE_O};
  int failures;
  int comparisons;
  rth_host_regs uut (.*);
  rth_host_model host (.clk_i(SYS_CLK_I), .data_i(DATA_O), .chip_sel_n_o(CHIP_SEL_N_I),
    .reg_sel_n_o(REG_SEL_N_I), .rd_wr_o(RD_WR_I), .addr0_o(ADDR0_I), .data_o(DATA_I));
  // ---------
  // Scenarios
  // ---------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [15:0] exp);
    logic [15:0] d;
    host.rd(d);
    chk(d, exp);
  endtask
  task automatic pulse(ref logic s);
    @(negedge SYS_CLK_I);
    s = 1'h1;
    @(negedge SYS_CLK_I);
    s = 1'h0;
  endtask
  task automatic t_ctl();
    for (int i = 0; i < 8; i++)
    begin
      host.wr(1'h0, 16'hFF00 | (16'h0001 << i));
      chk({8'h00, ctl}, 16'h0001 << i);
      st(16'h0240 | {4'h0, i == 6, i == 3, 1'h0, i == 0, i == 1, 7'h00});
    end
    host.wr(1'h0, 16'h0095);
    host.wr(1'h1, 16'h00FF);
    chk({8'h00, ctl}, 16'h0000);
  endtask
  task automatic t_cmd();
    CMD_WORD_I = 16'h0543;
    pulse(CMD_VALID_I);
    pulse(VALID_MSG_I);
    pulse(MSG_ERROR_I);
    chk({5'h00, LAST_CMD_O[10:0]}, 16'h0543);
    st(16'h622A);
    st(16'h022A);
    {CMD_ON_A_I, CMD_WORD_I} = {1'h1, 16'h0406};
    pulse(CMD_VALID_I);
    pulse(MODE_INHIBIT_FLAG_I);
    host.wr(1'h0, 16'h0004);
    chk({15'h0000, TERMINAL_FLAG_CTL_O}, 16'h0000);
    TRANSMIT_ACTIVE_N_I = 1'h0;
    st(16'h8046);
    TRANSMIT_ACTIVE_N_I = 1'h1;
    ADDR_PARITY_OK_I = 1'h0;
    pulse(ADDR_LATCH_LOAD_I);
    host.wr(1'h0, 16'h0003);
    chk({8'h00, ctl}, 16'h0000);
    st(16'h3046);
    ADDR_PARITY_OK_I = 1'h1;
    pulse(ADDR_LATCH_LOAD_I);
    st(16'h21C6);
    st(16'h01C6);
    chk(LAST_CMD_O, 16'h6406);
    {MODE_LAST_CMD_I, CMD_WORD_I} = {1'h1, 16'h07F2};
    pulse(CMD_VALID_I);
    MODE_LAST_CMD_I = 1'h0;
    chk(LAST_CMD_O, 16'h6406);
    pulse(MODE_OVERRIDE_FLAG_I);
    host.wr(1'h0, 16'h0044);
    chk({8'h00, ctl}, 16'h0044);
    pulse(SELFTEST_DONE_I);
    chk({15'h0000, SELFTEST_ACTIVE_O}, 16'h0000);
  endtask
  task automatic final_report();
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    SYS_CLK_I = 1'h0;
    forever #12.5 SYS_CLK_I = ~SYS_CLK_I;
  end
  initial
  begin
    repeat (4000) @(posedge SYS_CLK_I);
    failures++;
    final_report();
  end
  initial
  begin
    {RESET_N_I, CMD_VALID_I, CMD_ON_A_I, MODE_INHIBIT_FLAG_I, MODE_OVERRIDE_FLAG_I, MODE_LAST_CMD_I} = 6'h00;
    {ILLEGAL_CMD_I, ADDR_LATCH_LOAD_I, MSG_ERROR_I, VALID_MSG_I, SELFTEST_DONE_I, CMD_WORD_I} = 21'h000000;
    {ADDR_PARITY_OK_I, TRANSMIT_ACTIVE_N_I, RECEIVE_ACTIVE_N_I} = 3'h7;
    repeat (20) @(negedge SYS_CLK_I);
    RESET_N_I = 1'h1;
    st(16'h0240);
    chk(LAST_CMD_O, 16'hFFFF);
    t_ctl();
    t_cmd();
    final_report();
  end
endmodule // test_rth_host_regs
